// >>> shared/pcie_cap_pkg.sv
// Constants for the express capability configuration register bank
package pcie_cap_pkg;
   // Configuration byte offsets
   localparam logic [7:0]  OFF_SUBSYS_ID   = 8'h86;
   localparam logic [7:0]  OFF_CAP_ID      = 8'h90;
   localparam logic [7:0]  OFF_NEXT_PTR    = 8'h91;
   localparam logic [7:0]  OFF_EXP_CAPS    = 8'h92;
   localparam logic [7:0]  OFF_DEV_CAPS    = 8'h94;
   localparam logic [7:0]  OFF_GEN_CTRL    = 8'hD4;

   // Fixed and reset values
   localparam logic [15:0] SUBSYS_RST      = 16'h0000;
   localparam logic [7:0]  CAP_ID_VAL      = 8'h10;
   localparam logic [7:0]  NEXT_PTR_VAL    = 8'h00;
   localparam logic [3:0]  PORT_TYPE_VAL   = 4'h7;
   localparam logic [3:0]  CAP_VERSION_VAL = 4'h1;
   localparam logic [15:0] EXP_CAPS_VAL    = 16'h0071;
   localparam logic [31:0] DEV_CAPS_RST    = 32'h00000D82;
   localparam logic [2:0]  LAT_RST         = 3'h6;
   localparam logic [2:0]  MAX_PAYLOAD_SUPPORTED_VAL        = 3'h2;
   localparam logic [1:0]  PFS_VAL         = 2'h0;
   localparam logic [1:0]  SCALE_RST       = 2'h0;
   localparam logic [7:0]  VALUE_RST       = 8'h00;

   // Field positions in device capabilities
   localparam int          DC_SCALE_LSB    = 26;
   localparam int          DC_VALUE_LSB    = 18;
   localparam int          DC_L1_LSB       = 9;
   localparam int          DC_L0S_LSB      = 6;

   // Field positions in the message payload and the general control word
   localparam int          MSG_SCALE_LSB   = 8;
   localparam int          MSG_VALUE_LSB   = 0;
   localparam int          GC_L1_LSB       = 13;
   localparam int          GC_L0S_LSB      = 16;

   // Slot power multipliers, in milliwatts per unit of captured value
   localparam logic [9:0]  MULT_SCALE_0    = 10'd1000;
   localparam logic [9:0]  MULT_SCALE_1    = 10'd100;
   localparam logic [9:0]  MULT_SCALE_2    = 10'd10;
   localparam logic [9:0]  MULT_SCALE_3    = 10'd1;

   // Read answer follows the request by this many cycles
   localparam int          RD_LATENCY      = 1;

   // Register decode targets
   typedef enum logic [1:0] {
      SEL_NONE     = 2'b00,
      SEL_SUBSYS   = 2'b01,
      SEL_CAP_HEAD = 2'b10,
      SEL_DEV_CAPS = 2'b11
   } reg_sel_e;
endpackage

// >>> verilog/latency_field.sv
// One acceptable-latency field with reset default and floor clamp
`timescale 1ns/1ns
module latency_field
#(
   parameter logic [2:0] RST_VALUE = 3'h0
)
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       clear,
   // Programming
   input  wire logic       load,
   input  wire logic [2:0] wr_value,
   input  wire logic [2:0] phy_floor,
   // Result
   output logic [2:0]      value_reg
);
   logic [2:0] value_next;

   // Never load less than the physical layer needs to leave the state
   always_comb
   begin
      value_next = (wr_value < phy_floor) ? phy_floor : wr_value;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn || clear)
         value_reg <= RST_VALUE;
      else if (load)
         value_reg <= value_next;
   end
endmodule // latency_field

// >>> verilog/power_limit_calc.sv
// Slot power limit in milliwatts from captured scale and value
`timescale 1ns/1ns
module power_limit_calc
   import pcie_cap_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // Captured fields
   input  wire logic [1:0]  scale,
   input  wire logic [7:0]  value,
   // Result
   output logic [17:0]      limit_mw_reg
);
   logic [9:0] mult;

   always_comb
   begin
      case (scale)
         2'b00:   mult = MULT_SCALE_0;
         2'b01:   mult = MULT_SCALE_1;
         2'b10:   mult = MULT_SCALE_2;
         2'b11:   mult = MULT_SCALE_3;
         default: mult = MULT_SCALE_0;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         limit_mw_reg <= 18'h00000;
      else
         limit_mw_reg <= 18'(value) * 18'(mult);
   end
endmodule // power_limit_calc

// >>> verilog/pcie_cap_regs.sv
// Express capability configuration registers of the bridge
`timescale 1ns/1ns
module pcie_cap_regs
   import pcie_cap_pkg::*;
(
   // Clock and resets
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        pcie_reset_n,
   input  wire logic        global_reset_input_n,
   // Configuration access, dword data at a byte offset
   input  wire logic        cfg_rd,
   input  wire logic        cfg_wr,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [31:0] cfg_wdata,
   output logic             cfg_rd_valid,
   output logic [31:0]      cfg_rdata,
   output logic             cfg_wr_ack,
   // Subsystem identifier sources
   input  wire logic        eeprom_load,
   input  wire logic [15:0] eeprom_subsys_id,
   input  wire logic        alias_wr,
   input  wire logic [15:0] alias_subsys_id,
   // Received slot power limit message
   input  wire logic        spl_msg_valid,
   input  wire logic [9:0]  spl_msg_payload,
   // General control register write
   input  wire logic        gen_ctrl_wr,
   input  wire logic [31:0] gen_ctrl_data,
   // Physical layer exit latencies, encoded as the latency fields
   input  wire logic [2:0]  phy_l1_exit_lat,
   input  wire logic [2:0]  phy_l0s_exit_lat,
   // Derived slot power limit
   output logic [17:0]      slot_power_limit_mw
);
   import pcie_cap_pkg::*;

   logic [15:0] subsys_id_reg;
   logic [1:0]  captured_power_scale_reg;
   logic [7:0]  captured_power_value_reg;
   logic [2:0]  l1_acceptable_latency;
   logic [2:0]  l0s_acceptable_latency;
   logic        rd_valid_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        wr_ack_reg;
   logic        side_reset;
   reg_sel_e    sel;
   logic [15:0] express_capabilities;
   logic [31:0] device_capabilities;
   logic [2:0]  setting_a;
   logic [2:0]  setting_b;

   // Express and global reset act like power-on reset on the soft state
   assign side_reset = !pcie_reset_n || !global_reset_input_n;

   assign setting_a = gen_ctrl_data[GC_L1_LSB +: 3];
   assign setting_b = gen_ctrl_data[GC_L0S_LSB +: 3];

   // Subsystem identifier: no configuration write path reaches it
   always_ff @(posedge ref_clk)
   begin
      if (!rstn || side_reset)
         subsys_id_reg <= SUBSYS_RST;
      else if (alias_wr)
         subsys_id_reg <= alias_subsys_id;
      else if (eeprom_load)
         subsys_id_reg <= eeprom_subsys_id;
   end

   // Captured slot power limit fields
   always_ff @(posedge ref_clk)
   begin
      if (!rstn || side_reset)
      begin
         captured_power_scale_reg <= SCALE_RST;
         captured_power_value_reg <= VALUE_RST;
      end
      else if (spl_msg_valid)
      begin
         captured_power_scale_reg <= spl_msg_payload[MSG_SCALE_LSB +: 2];
         captured_power_value_reg <= spl_msg_payload[MSG_VALUE_LSB +: 8];
      end
   end

   // The two latency fields share one structure
   latency_field #(.RST_VALUE(LAT_RST)) u_l1_lat
   (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .clear     (side_reset),
      .load      (gen_ctrl_wr),
      .wr_value  (setting_a),
      .phy_floor (phy_l1_exit_lat),
      .value_reg (l1_acceptable_latency)
   );

   latency_field #(.RST_VALUE(LAT_RST)) u_l0s_lat
   (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .clear     (side_reset),
      .load      (gen_ctrl_wr),
      .wr_value  (setting_b),
      .phy_floor (phy_l0s_exit_lat),
      .value_reg (l0s_acceptable_latency)
   );

   power_limit_calc u_power
   (
      .ref_clk      (ref_clk),
      .rstn         (rstn),
      .scale        (captured_power_scale_reg),
      .value        (captured_power_value_reg),
      .limit_mw_reg (slot_power_limit_mw)
   );

   // Capabilities word: reserved, slot bit, port type, version
   assign express_capabilities = {7'h00, 1'b0,
                                  PORT_TYPE_VAL,
                                  CAP_VERSION_VAL};

   assign device_capabilities = {4'h0,
                                 captured_power_scale_reg,
                                 captured_power_value_reg,
                                 3'h0,
                                 1'b0, 1'b0, 1'b0,
                                 l1_acceptable_latency,
                                 l0s_acceptable_latency,
                                 1'b0, PFS_VAL,
                                 MAX_PAYLOAD_SUPPORTED_VAL};

   // Decode on the dword index; byte lanes are the host's concern
   always_comb
   begin
      if (cfg_addr[7:2] == OFF_SUBSYS_ID[7:2])
         sel = SEL_SUBSYS;
      else if (cfg_addr[7:2] == OFF_CAP_ID[7:2])
         sel = SEL_CAP_HEAD;
      else if (cfg_addr[7:2] == OFF_DEV_CAPS[7:2])
         sel = SEL_DEV_CAPS;
      else
         sel = SEL_NONE;
   end

   always_comb
   begin
      case (sel)
         SEL_SUBSYS:   rdata_next = {subsys_id_reg, 16'h0000};
         SEL_CAP_HEAD: rdata_next = {express_capabilities,
                                     NEXT_PTR_VAL,
                                     CAP_ID_VAL};
         SEL_DEV_CAPS: rdata_next = device_capabilities;
         default:      rdata_next = 32'h00000000;
      endcase
   end

   // Read answer one cycle after the request
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         rd_valid_reg <= 1'b0;
         rdata_reg    <= 32'h00000000;
      end
      else
      begin
         rd_valid_reg <= cfg_rd;
         if (cfg_rd)
            rdata_reg <= rdata_next;
      end
   end

   // Writes are acknowledged but nothing here listens to cfg_wdata
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         wr_ack_reg <= 1'b0;
      else
         wr_ack_reg <= cfg_wr;
   end

   assign cfg_rd_valid = rd_valid_reg;
   assign cfg_rdata    = rdata_reg;
   assign cfg_wr_ack   = wr_ack_reg;

   default clocking cb @(posedge ref_clk);
   endclocking

   default disable iff (!rstn);

   sequence s_rd_head;
      cfg_rd && !cfg_wr && cfg_addr[7:2] == OFF_CAP_ID[7:2];
   endsequence

   sequence s_spl_msg;
      spl_msg_valid && pcie_reset_n && global_reset_input_n;
   endsequence

   sequence s_quiet;
      !spl_msg_valid && !gen_ctrl_wr && !side_reset;
   endsequence

   sequence s_rd_subsys;
      cfg_rd && cfg_addr[7:2] == OFF_SUBSYS_ID[7:2];
   endsequence

   sequence s_rd_dev;
      cfg_rd && cfg_addr[7:2] == OFF_DEV_CAPS[7:2];
   endsequence

   property p_cap_id;
      s_rd_head |=> cfg_rd_valid && cfg_rdata[7:0] == 8'h10;
   endproperty
   a_cap_id: assert property (p_cap_id)
      else $error("express_capability_identifier byte wrong");

   property p_next_ptr;
      s_rd_head |=> cfg_rdata[15:8] == 8'h00;
   endproperty
   a_next_ptr: assert property (p_next_ptr)
      else $error("next pointer not zero");

   property p_exp_caps;
      s_rd_head |=> cfg_rdata[31:24] == 8'h00 && cfg_rdata[23:20] == 4'h7
                    && cfg_rdata[19:16] == 4'h1;
   endproperty
   a_exp_caps: assert property (p_exp_caps)
      else $error("express capabilities wrong");

   logic [1:0] cfg_rdata_peek_scale;
   assign cfg_rdata_peek_scale = device_capabilities[DC_SCALE_LSB +: 2];
   property p_scale_capture;
      s_spl_msg |=> cfg_rdata_peek_scale == $past(spl_msg_payload[9:8]);
   endproperty
   a_scale_capture: assert property (p_scale_capture)
      else $error("power scale not captured");

   property p_value_capture;
      s_spl_msg |=> device_capabilities[DC_VALUE_LSB +: 8] == $past(spl_msg_payload[7:0]);
   endproperty
   a_value_capture: assert property (p_value_capture)
      else $error("power value not captured");

   property p_power_calc;
      s_spl_msg ##1 !spl_msg_valid && !side_reset |=>
         slot_power_limit_mw == 18'($past(spl_msg_payload[7:0], 2))
            * (($past(spl_msg_payload[9:8], 2) == 2'b00) ? 18'd1000 :
               ($past(spl_msg_payload[9:8], 2) == 2'b01) ? 18'd100 :
               ($past(spl_msg_payload[9:8], 2) == 2'b10) ? 18'd10 : 18'd1);
   endproperty
   a_power_calc: assert property (p_power_calc)
      else $error("slot power limit wrong");

   property p_fixed_bits;
      device_capabilities[31:28] == 4'h0 && device_capabilities[17:12] == 6'h00
      && device_capabilities[5:0] == 6'h02;
   endproperty
   a_fixed_bits: assert property (p_fixed_bits)
      else $error("fixed device capability bits wrong");

   property p_l1_mirror;
      gen_ctrl_wr && !side_reset |=>
         l1_acceptable_latency == (($past(setting_a) < $past(phy_l1_exit_lat))
            ? $past(phy_l1_exit_lat) : $past(setting_a));
   endproperty
   a_l1_mirror: assert property (p_l1_mirror)
      else $error("Setting_a not mirrored");

   property p_l0s_mirror;
      gen_ctrl_wr && !side_reset |=>
         l0s_acceptable_latency == (($past(setting_b) < $past(phy_l0s_exit_lat))
            ? $past(phy_l0s_exit_lat) : $past(setting_b))
         && device_capabilities[8:6] == l0s_acceptable_latency;
   endproperty
   a_l0s_mirror: assert property (p_l0s_mirror)
      else $error("Setting_b below floor");

   property p_reset_value;
      disable iff (1'b0)
      !rstn |=> device_capabilities == 32'h00000D82 && subsys_id_reg == 16'h0000;
   endproperty
   a_reset_value: assert property (p_reset_value)
      else $error("reset values wrong");

   property p_side_reset;
      side_reset |=> subsys_id_reg == 16'h0000;
   endproperty
   a_side_reset: assert property (p_side_reset)
      else $error("subsystem_identifier survived reset");

   property p_alias;
      alias_wr && !side_reset |=> subsys_id_reg == $past(alias_subsys_id);
   endproperty
   a_alias: assert property (p_alias)
      else $error("alias write not taken");

   property p_write_ignored;
      (cfg_wr && !alias_wr && !eeprom_load) and s_quiet |=>
         cfg_wr_ack && $stable(device_capabilities) && $stable(subsys_id_reg);
   endproperty
   a_write_ignored: assert property (p_write_ignored)
      else $error("configuration write changed state");

   property p_subsys_read;
      s_rd_subsys |=> cfg_rd_valid && cfg_rdata == {$past(subsys_id_reg), 16'h0000};
   endproperty
   a_subsys_read: assert property (p_subsys_read)
      else $error("subsystem_identifier read wrong");

   property p_dev_read;
      s_rd_dev |=> cfg_rd_valid && cfg_rdata == $past(device_capabilities);
   endproperty
   a_dev_read: assert property (p_dev_read)
      else $error("device capabilities read wrong");

   property p_eeprom;
      eeprom_load && !alias_wr && !side_reset |=> subsys_id_reg == $past(eeprom_subsys_id);
   endproperty
   a_eeprom: assert property (p_eeprom)
      else $error("eeprom load not taken");

   property p_lat_clear;
      side_reset |=> l1_acceptable_latency == 3'h6 && l0s_acceptable_latency == 3'h6;
   endproperty
   a_lat_clear: assert property (p_lat_clear)
      else $error("latency fields not back to default");

   property p_answer_pulse;
      1'b1 |=> cfg_rd_valid == $past(cfg_rd) && cfg_wr_ack == $past(cfg_wr);
   endproperty
   a_answer_pulse: assert property (p_answer_pulse)
      else $error("read or write answer not one cycle after request");
endmodule // pcie_cap_regs

// >>> test/cfg_host_model.sv
// Host side model issuing configuration reads and writes
`timescale 1ns/1ns
module cfg_host_model
(
   // Clock
   input  wire logic        ref_clk,
   // Request
   output logic             cfg_rd,
   output logic             cfg_wr,
   output logic [7:0]       cfg_addr,
   output logic [31:0]      cfg_wdata,
   // Answer
   input  wire logic        cfg_rd_valid,
   input  wire logic [31:0] cfg_rdata,
   input  wire logic        cfg_wr_ack
);
   initial
   begin
      cfg_rd    = 1'b0;
      cfg_wr    = 1'b0;
      cfg_addr  = 8'h00;
      cfg_wdata = 32'h00000000;
   end

   // Released lines show the inverse, so a stale value never passes for a held one
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
      @(posedge ref_clk);
      #1;
      cfg_rd   = 1'b1;
      cfg_addr = a;
      @(posedge ref_clk);
      #1;
      cfg_rd   = 1'b0;
      cfg_addr = ~a;
      ok       = cfg_rd_valid;
      d        = cfg_rdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic ok);
      @(posedge ref_clk);
      #1;
      cfg_wr    = 1'b1;
      cfg_addr  = a;
      cfg_wdata = d;
      @(posedge ref_clk);
      #1;
      cfg_wr    = 1'b0;
      cfg_addr  = ~a;
      cfg_wdata = ~d;
      ok        = cfg_wr_ack;
   endtask
endmodule // cfg_host_model

// >>> test/pcie_capability_config_regs_test.sv
// Self-checking bench for the express capability register bank
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module pcie_capability_config_regs_test;
   import pcie_cap_pkg::*;
   logic        ref_clk, rstn, pcie_reset_n, global_reset_input_n;
   logic        cfg_rd, cfg_wr, cfg_rd_valid, cfg_wr_ack;
   logic [7:0]  cfg_addr;
   logic [31:0] cfg_wdata, cfg_rdata, gen_ctrl_data;
   logic        eeprom_load, alias_wr, spl_msg_valid, gen_ctrl_wr;
   logic [15:0] eeprom_subsys_id, alias_subsys_id;
   logic [9:0]  spl_msg_payload;
   logic [2:0]  phy_l1_exit_lat, phy_l0s_exit_lat;
   logic [17:0] slot_power_limit_mw;
   int          n_errors, checks_done;
   // Expected state of the device capabilities fields
   logic [1:0]  cs;
   logic [7:0]  cv;
   logic [2:0]  l1, l0;
   logic        ok;

   cfg_host_model host (.ref_clk(ref_clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rd_valid(cfg_rd_valid),
      .cfg_rdata(cfg_rdata), .cfg_wr_ack(cfg_wr_ack));

   pcie_cap_regs dut (.ref_clk(ref_clk), .rstn(rstn), .pcie_reset_n(pcie_reset_n),
      .global_reset_input_n(global_reset_input_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rd_valid(cfg_rd_valid),
      .cfg_rdata(cfg_rdata), .cfg_wr_ack(cfg_wr_ack), .eeprom_load(eeprom_load),
      .eeprom_subsys_id(eeprom_subsys_id), .alias_wr(alias_wr),
      .alias_subsys_id(alias_subsys_id), .spl_msg_valid(spl_msg_valid),
      .spl_msg_payload(spl_msg_payload), .gen_ctrl_wr(gen_ctrl_wr),
      .gen_ctrl_data(gen_ctrl_data), .phy_l1_exit_lat(phy_l1_exit_lat),
      .phy_l0s_exit_lat(phy_l0s_exit_lat), .slot_power_limit_mw(slot_power_limit_mw));

   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] exp_dc();
      return {4'h0, cs, cv, 6'h00, l1, l0, 6'h02};
   endfunction

   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic        v;
      host.rd(a, d, v);
      `CHK("read_valid", 1'b1, v)
      `CHK("read_data", e, d)
   endtask

   task automatic msg(input logic [9:0] p);
      step();
      spl_msg_valid   = 1'b1;
      spl_msg_payload = p;
      step();
      spl_msg_valid   = 1'b0;
      spl_msg_payload = ~p;
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Whole run is about 110 cycles; over twenty times that means a hang
   initial
   begin
      #20000;
      n_errors++;
      summarize();
   end

   initial
   begin
      static logic [7:0]  addrs [4] = '{8'h86, 8'h90, 8'h94, 8'h88};
      static logic [7:0]  vals [4]  = '{8'hFF, 8'h3C, 8'hC3, 8'h80};
      static int          mult [4]  = '{1000, 100, 10, 1};
      static logic [2:0]  w1 [4] = '{3'h3, 3'h0, 3'h1, 3'h7};
      static logic [2:0]  w0 [4] = '{3'h5, 3'h7, 3'h2, 3'h1};
      static logic [2:0]  f1 [4] = '{3'h0, 3'h0, 3'h4, 3'h4};
      static logic [2:0]  f0 [4] = '{3'h0, 3'h0, 3'h2, 3'h2};
      static logic [2:0]  e1 [4] = '{3'h3, 3'h0, 3'h4, 3'h7};
      static logic [2:0]  e0 [4] = '{3'h5, 3'h7, 3'h2, 3'h2};
      static logic [31:0] rv [4];
      n_errors = 0;
      checks_done = 0;
      rstn = 1'b0;
      pcie_reset_n = 1'b1;
      global_reset_input_n = 1'b1;
      eeprom_load = 1'b0;
      alias_wr = 1'b0;
      eeprom_subsys_id = 16'h0000;
      alias_subsys_id = 16'h0000;
      spl_msg_valid = 1'b0;
      spl_msg_payload = 10'h000;
      gen_ctrl_wr = 1'b0;
      gen_ctrl_data = 32'h00000000;
      phy_l1_exit_lat = 3'h0;
      phy_l0s_exit_lat = 3'h0;
      cs = 2'h0;
      cv = 8'h00;
      l1 = 3'h6;
      l0 = 3'h6;
      repeat (16) @(posedge ref_clk);
      #1;
      rstn = 1'b1;

      rdchk(8'h86, 32'h00000000);
      rdchk(8'h90, 32'h00710010);
      rdchk(8'h94, exp_dc());
      rdchk(8'h88, 32'h00000000);
      $display("test reset_values done");

      rv = '{32'h00000000, 32'h00710010, exp_dc(), 32'h00000000};
      for (int i = 0; i < 4; i++)
      begin
         host.wr(addrs[i], 32'hFFFFFFFF, ok);
         `CHK("write_ack", 1'b1, ok)
         rdchk(addrs[i], rv[i]);
      end
      $display("test read_only_writes done");

      step();
      eeprom_load = 1'b1;
      eeprom_subsys_id = 16'h1234;
      step();
      eeprom_load = 1'b0;
      eeprom_subsys_id = 16'hEDCB;
      rdchk(8'h86, 32'h12340000);
      step();
      eeprom_load = 1'b1;
      alias_wr = 1'b1;
      eeprom_subsys_id = 16'h5555;
      alias_subsys_id = 16'hA5C3;
      step();
      eeprom_load = 1'b0;
      alias_wr = 1'b0;
      eeprom_subsys_id = 16'hAAAA;
      alias_subsys_id = 16'h5A3C;
      rdchk(8'h86, 32'hA5C30000);
      $display("test subsystem_identifier done");

      for (int s = 0; s < 4; s++)
      begin
         msg({s[1:0], vals[s]});
         cs = s[1:0];
         cv = vals[s];
         rdchk(8'h94, exp_dc());
         `CHK("power_limit", 18'(int'(vals[s]) * mult[s]), slot_power_limit_mw)
      end
      $display("test power_limit done");

      // Bits outside both fields are set so a wrong slice shows up
      for (int i = 0; i < 4; i++)
      begin
         step();
         phy_l1_exit_lat = f1[i];
         phy_l0s_exit_lat = f0[i];
         gen_ctrl_wr = 1'b1;
         gen_ctrl_data = 32'hFFF81FFF | {13'h0000, w0[i], w1[i], 13'h0000};
         step();
         gen_ctrl_wr = 1'b0;
         gen_ctrl_data = 32'h00000000;
         l1 = e1[i];
         l0 = e0[i];
         rdchk(8'h94, exp_dc());
      end
      $display("test latency done");

      for (int k = 0; k < 3; k++)
      begin
         step();
         alias_wr = 1'b1;
         alias_subsys_id = 16'h0F0F;
         step();
         alias_wr = 1'b0;
         msg(10'h2E7);
         step();
         pcie_reset_n = (k != 0);
         global_reset_input_n = (k != 1);
         rstn = (k != 2);
         step();
         pcie_reset_n = 1'b1;
         global_reset_input_n = 1'b1;
         rstn = 1'b1;
         cs = 2'h0;
         cv = 8'h00;
         l1 = 3'h6;
         l0 = 3'h6;
         rdchk(8'h86, 32'h00000000);
         rdchk(8'h94, exp_dc());
         `CHK("power_limit", 18'h00000, slot_power_limit_mw)
      end
      $display("test resets done");
      summarize();
   end
endmodule // pcie_capability_config_regs_test
